// ### rtl/qbs_map.svh
/*
 * constants of the burst sram link: beat timing and controller register map
 * assumes one pclk edge per input clock rise, positive and negative alternating
 */
`ifndef QBS_MAP_SVH
`define QBS_MAP_SVH

// burst shape, in link beats (one beat per pclk edge)
`define QBS_BURST          4
`define QBS_WR_FIRST       2
`define QBS_LAT_PLL_ON     5
`define QBS_LAT_PLL_OFF    2

// controller register byte offsets
`define QBS_REG_CTRL       8'h00
`define QBS_REG_CMD        8'h04
`define QBS_REG_RADDR      8'h08
`define QBS_REG_WADDR      8'h0C
`define QBS_REG_WDATA      8'h10
`define QBS_REG_RDATA      8'h20

// field positions
`define QBS_CTRL_PLL_BIT   0
`define QBS_CMD_RD_BIT     0
`define QBS_CMD_WR_BIT     1

// reset values
`define QBS_CTRL_RESET     1'h1

`endif

// ### rtl/qbs_pkg.sv
/*
 * shared types of the burst sram device and its controller
 * assumes nothing of its surroundings
 */
package qbs_pkg;

    // operation started on the previous positive clock rise
    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} qbs_op_t;

endpackage : qbs_pkg

// ### rtl/qbs_link_if.sv
/*
 * link between the burst sram and its controller, one modport per end
 * assumes both ends run on the same pclk; q is qualified by q_oe
 */
`timescale 1ns/100ps

interface qbs_link_if #(
    parameter int ADDR_W = 20,
    parameter int WORD_W = 18,
    parameter int NB     = 2
);
    logic              k_rise;        // this beat is a positive clock rise
    logic              pll_disable_n; // high: long latency mode
    logic              rps_n;
    logic              wps_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
    logic [NB-1:0]     bws_n;
    logic [WORD_W-1:0] q;
    logic              q_oe;          // high while q is driven

    modport dev (
        input  k_rise, pll_disable_n, rps_n, wps_n, addr, d, bws_n,
        output q, q_oe
    );
    modport ctrl (
        output k_rise, pll_disable_n, rps_n, wps_n, addr, d, bws_n,
        input  q, q_oe
    );
endinterface : qbs_link_if

// ### rtl/qbs_sram_dev.sv
/*
 * burst sram device end: four word banks, read and write ports
 * assumes the controller drives the link on pclk and marks positive rises
 */
// Behaviour
// - every access is a four word burst
// - long latency mode: first word five beats later
// - short latency mode: first word two beats later
// - requests start only on positive clock rises
// - write data registered on every beat
// - read data launched from register every beat
// - storage is four banks, one per word
// - read select stores address, starts read
// - lowest word first, one word per beat
// - back to back read request ignored
// - reads every other rise stream without gaps
// - deselected: finish bursts, then release outputs
// - write select latches address, starts write
// - write words start two beats after request
// - four words written to bank together
// - back to back write request ignored
// - writes every other rise take every beat
// - deselected write port ignores its inputs once bursts finish
// - byte selects sampled with each word
// - only selected bytes are written
// - read after write returns newest data
// - both selected: alternate, read first
`timescale 1ns/100ps
`include "qbs_map.svh"

module qbs_sram_dev #(
    parameter int ADDR_W = 20,
    parameter int WORD_W = 18,
    parameter int BYTE_W = 9
) (
    // clock and reset
    input  logic pclk,
    input  logic presetn,
    input  logic ce,
    // link to the controller
    qbs_link_if.dev lnk
);
    localparam int NB    = WORD_W / BYTE_W;
    localparam int DEPTH = 2 ** ADDR_W;

    typedef struct packed {
        qbs_pkg::qbs_op_t          last_op;
        logic [1:0]                rd_act;
        logic [1:0][3:0]           rd_cnt;
        logic [1:0][ADDR_W-1:0]    rd_addr;
        logic [1:0]                rd_fwd;
        logic                      wr_act;
        logic [2:0]                wr_cnt;
        logic [ADDR_W-1:0]         wr_addr;
        logic                      wr_nxt;
        logic [ADDR_W-1:0]         wr_nxt_addr;
        logic [3:0][WORD_W-1:0]    wr_buf;
        logic [3:0][NB-1:0]        wr_ben;
        logic [WORD_W-1:0]         q;
        logic                      q_oe;
    } qbs_dev_st_t;

    qbs_dev_st_t               r;
    qbs_dev_st_t               next_r;
    logic [3:0][1:0][WORD_W-1:0] bank_q;
    logic                      commit;
    logic [3:0][WORD_W-1:0]    commit_data;
    logic [3:0][NB-1:0]        commit_ben;
    logic [ADDR_W-1:0]         commit_addr;

    // one bank per burst word position, byte lane write enables
    genvar w;
    genvar s;
    generate
        for (w = 0; w < `QBS_BURST; w++)
        begin : g_bank
            logic [WORD_W-1:0] bank [0:DEPTH-1];
            always_ff @(posedge pclk)
            begin
                if (ce && commit)
                begin
                    for (int b = 0; b < NB; b++)
                    begin
                        if (commit_ben[w][b])
                            bank[commit_addr][b*BYTE_W +: BYTE_W] <=
                                commit_data[w][b*BYTE_W +: BYTE_W];
                    end
                end
            end
            // each read slot looks at its own address
            for (s = 0; s < 2; s++)
            begin : g_slot
                assign bank_q[w][s] = bank[r.rd_addr[s]];
            end
        end
    endgenerate

    // next state of both ports
    always_comb
    begin
        logic [3:0]        lat;
        logic              take_rd;
        logic              take_wr;
        logic              wr_done;
        logic [1:0]        idx;
        logic [WORD_W-1:0] word;
        logic [3:0]        widx;
        logic              slot;
        lat         = 4'h0;
        take_rd     = 1'b0;
        take_wr     = 1'b0;
        wr_done     = 1'b0;
        idx         = 2'h0;
        word        = '0;
        widx        = 4'h0;
        slot        = 1'b0;
        next_r      = r;
        commit      = 1'b0;
        commit_data = r.wr_buf;
        commit_ben  = r.wr_ben;
        commit_addr = r.wr_addr;

        // latency picked by the mode pin
        lat = lnk.pll_disable_n ? 4'(`QBS_LAT_PLL_ON)
                                : 4'(`QBS_LAT_PLL_OFF);

        // selects count only on positive rises; read wins unless after read
        if (lnk.k_rise)
        begin
            take_rd = !lnk.rps_n && r.last_op != qbs_pkg::OP_READ;
            take_wr = !lnk.wps_n && r.last_op != qbs_pkg::OP_WRITE
                      && !take_rd;
            next_r.last_op = take_rd ? qbs_pkg::OP_READ :
                             take_wr ? qbs_pkg::OP_WRITE : qbs_pkg::OP_IDLE;
        end

        // write burst: collect four words, then commit all at once
        if (r.wr_act)
        begin
            if (r.wr_cnt >= 3'(`QBS_WR_FIRST))
            begin
                widx = 4'(r.wr_cnt - 3'(`QBS_WR_FIRST));
                next_r.wr_buf[widx[1:0]] = lnk.d;
                next_r.wr_ben[widx[1:0]] = ~lnk.bws_n;
            end
            if (r.wr_cnt == 3'(`QBS_WR_FIRST + `QBS_BURST - 1))
            begin
                commit         = 1'b1;
                commit_data[3] = lnk.d;
                commit_ben[3]  = ~lnk.bws_n;
                wr_done        = 1'b1;
                // a queued burst takes over the buffer from here
                if (r.wr_nxt)
                begin
                    next_r.wr_addr = r.wr_nxt_addr;
                    next_r.wr_cnt  = 3'(`QBS_WR_FIRST);
                    next_r.wr_nxt  = 1'b0;
                end
                else
                    next_r.wr_act = 1'b0;
            end
            else
                next_r.wr_cnt = r.wr_cnt + 3'h1;
        end
        if (take_wr)
        begin
            // the previous burst still owns the buffer for one beat
            if (r.wr_act && !wr_done)
            begin
                next_r.wr_nxt      = 1'b1;
                next_r.wr_nxt_addr = lnk.addr;
            end
            else
            begin
                next_r.wr_act  = 1'b1;
                next_r.wr_cnt  = 3'h1;
                next_r.wr_addr = lnk.addr;
            end
        end

        // read slots: two may overlap in either latency mode
        next_r.q_oe = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            if (r.rd_act[i])
            begin
                if (r.rd_cnt[i] >= lat && r.rd_cnt[i] < lat + 4'h4)
                begin
                    idx  = 2'(r.rd_cnt[i] - lat);
                    word = bank_q[idx][i];
                    // older write still in the buffer: take its bytes
                    if (r.rd_fwd[i] &&
                        r.wr_cnt > 3'(`QBS_WR_FIRST) + 3'(idx))
                    begin
                        for (int b = 0; b < NB; b++)
                        begin
                            if (r.wr_ben[idx][b])
                                word[b*BYTE_W +: BYTE_W] =
                                    r.wr_buf[idx][b*BYTE_W +: BYTE_W];
                        end
                    end
                    next_r.q    = word;
                    next_r.q_oe = 1'b1;
                end
                if (r.rd_cnt[i] == lat + 4'h3)
                    next_r.rd_act[i] = 1'b0;
                next_r.rd_cnt[i] = r.rd_cnt[i] + 4'h1;
                if (commit)
                    next_r.rd_fwd[i] = 1'b0; // bank now holds the data
            end
        end
        if (take_rd)
        begin
            slot = r.rd_act[0] && next_r.rd_act[0];
            next_r.rd_act[slot]  = 1'b1;
            next_r.rd_cnt[slot]  = 4'h1;
            next_r.rd_addr[slot] = lnk.addr;
            next_r.rd_fwd[slot]  = r.wr_act && r.wr_addr == lnk.addr
                                   && !wr_done;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else if (ce)
            r <= next_r;
    end

    assign lnk.q    = r.q;
    assign lnk.q_oe = r.q_oe;

endmodule : qbs_sram_dev

// ### rtl/qbs_sram_ctrl.sv
/*
 * controller end: apb registers drive single read and write bursts
 * assumes an apb master on pclk and the sram device on the link
 */
`timescale 1ns/100ps
`include "qbs_map.svh"

module qbs_sram_ctrl #(
    parameter int ADDR_W = 20,
    parameter int WORD_W = 18,
    parameter int BYTE_W = 9
) (
    // clock and reset
    input  logic        pclk,
    input  logic        presetn,
    input  logic        ce,
    // apb slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    // link to the device
    qbs_link_if.ctrl    lnk
);
    localparam int NB = WORD_W / BYTE_W;

    typedef struct packed {
        logic                   k_rise;
        logic                   rps_n;
        logic                   wps_n;
        logic [ADDR_W-1:0]      addr;
        logic [WORD_W-1:0]      d;
        logic [NB-1:0]          bws_n;
        logic                   pll_dis_n;
        logic                   pend_rd;
        logic                   pend_wr;
        logic                   last_rd;
        logic [ADDR_W-1:0]      raddr;
        logic [ADDR_W-1:0]      waddr;
        logic [3:0][WORD_W-1:0] wdata;
        logic [3:0][NB-1:0]     wben;
        logic [3:0][WORD_W-1:0] rdata;
        logic                   rd_act;
        logic [3:0]             rd_cnt;
        logic                   wr_act;
        logic [2:0]             wr_cnt;
        logic [31:0]            prdata;
        logic                   pslverr;
    } qbs_ctrl_st_t;

    qbs_ctrl_st_t r;
    qbs_ctrl_st_t next_r;

    // next state: apb decode, burst issue and data capture
    always_comb
    begin
        logic [3:0] lat;
        logic [3:0] widx;
        logic       go_rd;
        logic       hit;
        lat    = r.pll_dis_n ? 4'(`QBS_LAT_PLL_ON) : 4'(`QBS_LAT_PLL_OFF);
        widx   = paddr[5:2] & 4'h3;
        go_rd  = 1'b0;
        hit    = 1'b1;
        next_r = r;

        // registered read data, ready for the access phase
        if (psel && !penable)
        begin
            next_r.prdata = 32'h0;
            case (paddr)
                `QBS_REG_CTRL:
                    next_r.prdata[`QBS_CTRL_PLL_BIT] = r.pll_dis_n;
                `QBS_REG_CMD:
                    next_r.prdata[1:0] = {r.pend_wr | r.wr_act,
                                          r.pend_rd | r.rd_act};
                `QBS_REG_RADDR: next_r.prdata[ADDR_W-1:0] = r.raddr;
                `QBS_REG_WADDR: next_r.prdata[ADDR_W-1:0] = r.waddr;
                default:
                begin
                    if (paddr[7:4] == `QBS_REG_WDATA >> 4)
                        next_r.prdata[WORD_W+NB-1:0] =
                            {r.wben[widx[1:0]], r.wdata[widx[1:0]]};
                    else if (paddr[7:4] == `QBS_REG_RDATA >> 4)
                        next_r.prdata[WORD_W-1:0] = r.rdata[widx[1:0]];
                    else
                        hit = 1'b0;
                end
            endcase
            next_r.pslverr = !hit || paddr[1:0] != 2'h0;
        end

        // apb write takes effect at the access edge only
        if (psel && penable && pwrite && !r.pslverr)
        begin
            case (paddr)
                `QBS_REG_CTRL: next_r.pll_dis_n = pwdata[`QBS_CTRL_PLL_BIT];
                `QBS_REG_CMD:
                begin
                    // ignored while that port is busy
                    if (pwdata[`QBS_CMD_RD_BIT] && !r.pend_rd && !r.rd_act)
                        next_r.pend_rd = 1'b1;
                    if (pwdata[`QBS_CMD_WR_BIT] && !r.pend_wr && !r.wr_act)
                        next_r.pend_wr = 1'b1;
                end
                `QBS_REG_RADDR: next_r.raddr = pwdata[ADDR_W-1:0];
                `QBS_REG_WADDR: next_r.waddr = pwdata[ADDR_W-1:0];
                default:
                begin
                    if (paddr[7:4] == `QBS_REG_WDATA >> 4)
                    begin
                        next_r.wdata[widx[1:0]] = pwdata[WORD_W-1:0];
                        next_r.wben[widx[1:0]]  = pwdata[WORD_W +: NB];
                    end
                end
            endcase
        end

        // beat phase and one select per positive rise
        next_r.k_rise = !r.k_rise;
        next_r.rps_n  = 1'b1;
        next_r.wps_n  = 1'b1;
        if (!r.k_rise)
        begin
            go_rd = r.pend_rd && !(r.last_rd && r.pend_wr);
            next_r.last_rd = go_rd;
            if (go_rd)
            begin
                next_r.rps_n   = 1'b0;
                next_r.addr    = r.raddr;
                next_r.pend_rd = 1'b0;
                next_r.rd_act  = 1'b1;
                next_r.rd_cnt  = 4'h0;
            end
            else if (r.pend_wr)
            begin
                next_r.wps_n   = 1'b0;
                next_r.addr    = r.waddr;
                next_r.pend_wr = 1'b0;
                next_r.wr_act  = 1'b1;
                next_r.wr_cnt  = 3'h0;
            end
        end

        // read: take each word one beat after the device launches it
        if (r.rd_act)
        begin
            next_r.rd_cnt = r.rd_cnt + 4'h1;
            if (r.rd_cnt > lat)
                next_r.rdata[2'(r.rd_cnt - lat - 4'h1)] = lnk.q;
            if (r.rd_cnt == lat + 4'h4)
                next_r.rd_act = 1'b0; // spacing kept by busy
        end

        // write: each word set up one beat before the device samples it,
        // first word sampled on the positive rise after the request
        if (r.wr_act)
        begin
            next_r.wr_cnt = r.wr_cnt + 3'h1;
            if (r.wr_cnt == 3'h5)
                next_r.wr_act = 1'b0; // spacing kept by busy
            else if (r.wr_cnt != 3'h0)
            begin
                next_r.d     = r.wdata[2'(r.wr_cnt - 3'h1)];
                next_r.bws_n = ~r.wben[2'(r.wr_cnt - 3'h1)];
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r           <= '0;
            r.rps_n     <= 1'b1;
            r.wps_n     <= 1'b1;
            r.bws_n     <= '1;
            r.pll_dis_n <= `QBS_CTRL_RESET;
        end
        else if (ce)
            r <= next_r;
    end

    assign prdata            = r.prdata;
    assign pslverr           = r.pslverr;
    assign pready            = 1'b1; // zero wait states
    assign lnk.k_rise        = r.k_rise;
    assign lnk.pll_disable_n = r.pll_dis_n;
    assign lnk.rps_n         = r.rps_n;
    assign lnk.wps_n         = r.wps_n;
    assign lnk.addr          = r.addr;
    assign lnk.d             = r.d;
    assign lnk.bws_n         = r.bws_n;

endmodule : qbs_sram_ctrl

// ### verification/qbs_link_monitor.sv
/*
 * link checker of the burst sram: latency, release and select timing
 * assumes ce held high and pll mode changed only while the link is idle
 */
`timescale 1ns/100ps

module qbs_link_monitor #(
    parameter int WORD_W = 18
) (
    // clock and reset
    input logic              pclk,
    input logic              presetn,
    // link signals
    input logic              k_rise,
    input logic              pll_disable_n,
    input logic              rps_n,
    input logic              wps_n,
    input logic [WORD_W-1:0] q,
    input logic              q_oe
);
    typedef struct packed {
        logic       last_rd;
        logic       last_wr;
        logic [8:0] hist;
    } qbs_mon_t;
    qbs_mon_t st;
    qbs_mon_t next_st;
    logic     rd_acc;
    logic     wr_acc;

    // starts as the device takes them; a read loses only after a read
    assign rd_acc = k_rise && !rps_n && !st.last_rd;
    assign wr_acc = k_rise && !wps_n && !st.last_wr && !rd_acc;

    // last rise outcome and a short history of read starts
    always_comb
    begin
        next_st = st;
        if (k_rise)
        begin
            next_st.last_rd = rd_acc;
            next_st.last_wr = wr_acc;
        end
        next_st.hist = {st.hist[7:0], rd_acc};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_lat_long;
        rd_acc && pll_disable_n |-> ##6 q_oe [*4];
    endproperty
    a_lat_long: assert property (p_lat_long)
        else $error("long latency burst late or short");
    property p_lat_short;
        rd_acc && !pll_disable_n |-> ##3 q_oe [*4];
    endproperty
    a_lat_short: assert property (p_lat_short)
        else $error("short latency burst late or short");
    // any driven word must belong to a read taken at the right distance
    property p_oe_cause;
        q_oe |-> (pll_disable_n ? |st.hist[8:5] : |st.hist[5:2]);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("read data driven without a matching read");
    property p_k_alt;
        // sampled reset keeps the release edge, with k_rise still 0, out
        presetn |=> k_rise != $past(k_rise);
    endproperty
    a_k_alt: assert property (p_k_alt)
        else $error("positive rise marker does not alternate");
    property p_sel_rise;
        !rps_n || !wps_n |-> k_rise;
    endproperty
    a_sel_rise: assert property (p_sel_rise)
        else $error("port select off a positive rise");
    property p_rd_space;
        !rps_n |=> rps_n [*3];
    endproperty
    a_rd_space: assert property (p_rd_space)
        else $error("read selects too close");
    property p_wr_space;
        !wps_n |=> wps_n [*3];
    endproperty
    a_wr_space: assert property (p_wr_space)
        else $error("write selects too close");
    property p_q_hold;
        !q_oe ##1 !q_oe |-> $stable(q);
    endproperty
    a_q_hold: assert property (p_q_hold)
        else $error("read data moved while released");

    c_rd_long: cover property (rd_acc && pll_disable_n);
    c_rd_short: cover property (rd_acc && !pll_disable_n);
    c_wr: cover property (wr_acc);
    c_fwd: cover property (wr_acc ##[2:4] rd_acc);
endmodule : qbs_link_monitor

// ### verification/quad_rate_burst_sram_ports_bench.sv
/*
 * bench: controller and device joined, driven over apb; a second device
 * assumes the map header; the second device is driven directly
 */
`timescale 1ns/100ps
`include "qbs_map.svh"

module quad_rate_burst_sram_ports_bench;
    localparam int AW = 6;
    typedef struct packed {
        logic        pll;
        logic [5:0]  addr;
        logic [17:0] base;
        logic [1:0]  be;
        logic        fwd;
    } qbs_row_t;

    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    logic [17:0] shadow [64][4];
    qbs_row_t    rows [5];
    int          beats;
    int          errors;
    int          checks;

    qbs_link_if #(.ADDR_W(AW)) lnk ();
    qbs_link_if #(.ADDR_W(AW)) lnk2 ();

    qbs_sram_dev #(.ADDR_W(AW)) u_qbs_sram_dev (
        .pclk(pclk), .presetn(presetn), .ce(ce), .lnk(lnk));
    qbs_sram_dev #(.ADDR_W(AW)) u_qbs_sram_dev_2 (
        .pclk(pclk), .presetn(presetn), .ce(ce), .lnk(lnk2));
    qbs_sram_ctrl #(.ADDR_W(AW)) u_qbs_sram_ctrl (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk));
    qbs_link_monitor u_qbs_link_monitor (
        .pclk(pclk), .presetn(presetn), .k_rise(lnk.k_rise),
        .pll_disable_n(lnk.pll_disable_n), .rps_n(lnk.rps_n),
        .wps_n(lnk.wps_n), .q(lnk.q), .q_oe(lnk.q_oe));

    // 100 MHz
    always #5 pclk = ~pclk;

    task automatic summarize();
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            summarize();
        end
    endtask : apb

    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `QBS_REG_CMD, 32'h0);
            n++;
        end
        while (rd[1:0] !== 2'h0 && n < 40);
        if (rd[1:0] !== 2'h0)
        begin
            errors++;
            summarize();
        end
    endtask : wait_idle

    // write a burst, read it back; fwd issues the read right behind
    task automatic run_row(input qbs_row_t r);
        logic [17:0] w;
        apb(1'b1, `QBS_REG_CTRL, {31'h0, r.pll});
        apb(1'b1, `QBS_REG_WADDR, {26'h0, r.addr});
        apb(1'b1, `QBS_REG_RADDR, {26'h0, r.addr});
        for (int i = 0; i < 4; i++)
        begin
            w = r.base + 18'(i);
            apb(1'b1, 8'(`QBS_REG_WDATA + 4 * i), {12'h0, r.be, w});
            for (int b = 0; b < 2; b++)
                if (r.be[b])
                    shadow[r.addr][i][9*b +: 9] = w[9*b +: 9];
        end
        apb(1'b1, `QBS_REG_CMD, 32'h2);
        if (!r.fwd)
            wait_idle();
        apb(1'b1, `QBS_REG_CMD, 32'h1);
        wait_idle();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(`QBS_REG_RDATA + 4 * i), 32'h0);
            chk(rd, {14'h0, shadow[r.addr][i]});
        end
    endtask : run_row

    // second device: selects on consecutive rises, q_oe beats counted
    task automatic probe2(input logic rsel_n, input logic wsel_n,
                          input int rises);
        beats = 0;
        for (int j = 0; j < 24; j++)
        begin
            @(posedge pclk);
            beats += int'(lnk2.q_oe === 1'b1);
            lnk2.k_rise <= ~j[0];
            lnk2.rps_n  <= (!j[0] && j < 2 * rises) ? rsel_n : 1'b1;
            lnk2.wps_n  <= (!j[0] && j < 2 * rises) ? wsel_n : 1'b1;
            lnk2.d      <= 18'(j);
        end
    endtask : probe2

    initial
    begin
        {pclk, presetn, psel, penable, pwrite} = '0;
        {paddr, pwdata, errors, checks} = '0;
        ce = 1'b1;
        {lnk2.k_rise, lnk2.pll_disable_n, lnk2.addr, lnk2.d} = '0;
        {lnk2.rps_n, lnk2.wps_n, lnk2.bws_n} = 4'hC;
        rows[0] = '{1'b1, 6'h05, 18'h12340, 2'h3, 1'b0};
        rows[1] = '{1'b0, 6'h3F, 18'h2BCD0, 2'h3, 1'b0};
        rows[2] = '{1'b1, 6'h05, 18'h3F0A0, 2'h1, 1'b0};
        rows[3] = '{1'b0, 6'h05, 18'h01100, 2'h2, 1'b1};
        rows[4] = '{1'b1, 6'h00, 18'h3FFF0, 2'h3, 1'b1};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[r])
            run_row(rows[r]);
        // read data registers ignore writes without error
        apb(1'b1, `QBS_REG_RDATA, 32'h15555);
        chk(32'(err), 32'h0);
        apb(1'b0, `QBS_REG_RDATA, 32'h0);
        chk(rd, {14'h0, shadow[0][0]});
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0A, 32'h0);
        chk(32'(err), 32'h1);
        // refused second read, then a clash from idle: read, write, read
        probe2(1'b0, 1'b1, 2);
        chk(32'(beats), 32'h4);
        probe2(1'b0, 1'b0, 3);
        chk(32'(beats), 32'h8);
        chk(32'(lnk2.q_oe), 32'h0);
        // reset in mid-run restores the register defaults
        apb(1'b1, `QBS_REG_CTRL, 32'h0);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `QBS_REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `QBS_REG_CMD, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `QBS_REG_WDATA, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : quad_rate_burst_sram_ports_bench
